/* File: core/coef_regs_pkg.sv */
// Purpose: constants shared by the coefficient boot and pin direction bank
// Assumes: 8-bit register offsets on the device control bus
// Notes: offsets are byte addresses of the control bus
package coef_regs_pkg;
	localparam logic [7:0] ctrl0_offset = 8'h56;
	localparam logic [7:0] addr_high_offset = 8'h58;
	localparam logic [7:0] addr_middle_offset = 8'h59;
	localparam logic [7:0] addr_low_offset = 8'h5a;
	localparam logic [7:0] boot_status_offset = 8'h5b;
	localparam logic [7:0] biquad_ctrl_offset = 8'h5c;
	localparam logic [7:0] supply_offset = 8'h5e;
	localparam logic [7:0] pin_dir_offset = 8'h60;
	localparam int load_source_bit = 0;
	localparam int wide_address_bit = 5;
	localparam int done_bit = 0;
	localparam int crc_error_bit = 1;
	localparam int first_coef_bit = 0;
	localparam logic [7:0] ctrl0_reset = 8'h00;
	localparam logic [7:0] addr_reset = 8'h00;
	localparam logic [7:0] biquad_ctrl_reset = 8'h00;
	localparam logic [7:0] supply_reset = 8'h00;
	localparam logic [2:0] pin_dir_reset = 3'h0;
	localparam logic [1:0] boot_status_reset = 2'h0;
	localparam logic [7:0] ctrl0_mask = 8'h21;
endpackage

/* File: core/boot_status_if.sv */
// Purpose: carries boot load events and status between modules
// Assumes: single clock domain
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface boot_status_if;
	logic load_start;
	logic load_done;
	logic crc_error;
	logic [1:0] status;
	modport tracker (input load_start, input load_done, input crc_error,
		output status);
	modport bank (output load_start, output load_done, output crc_error,
		input status);
endinterface
`default_nettype wire

/* File: core/boot_status_tracker.sv */
// Purpose: holds the done and checksum result bits of the boot load
// Assumes: load engine pulses start and done, and holds error valid while done is high
// Notes: a done in the start cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
module boot_status_tracker
	import coef_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	boot_status_if.tracker bs
);
	// ==========================================
	// status flags
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bs.status <= boot_status_reset;
		end else begin
			if (bs.load_done) begin
				bs.status[done_bit] <= 1'b1;
				bs.status[crc_error_bit] <= bs.crc_error;
			end else if (bs.load_start) begin
				bs.status <= boot_status_reset;
			end
		end
	end
endmodule
`default_nettype wire

/* File: core/coef_boot_gpio_dir_regs.sv */
// Overview of operation
// - middle start address byte, read-write
// - low start address byte, resets zero
// - status bit 1 flags checksum failure
// - status bit 0 flags load finished
// - status read-only, reserved bits zero
// - host marks first biquad coefficient write
// - supply code equals volts times 8.428
// - supply register read-only, zero after reset
// - direction bits: 1 output, 0 input
// - direction resets to all inputs
// - high start address byte register
// - load source bit: host or memory
// - wide address enable sends three bytes
//
// Purpose: register bank for coefficient boot, supply code, pin direction
// Assumes: decoded control-bus write/read strobes, synchronous inputs
// Notes: read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module coef_boot_gpio_dir_regs
	import coef_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic load_start,
	input wire logic load_done,
	input wire logic crc_error,
	input wire logic sample_valid,
	input wire logic [7:0] sample_code,
	input wire logic biquad_coef_write,
	output logic load_from_memory,
	output logic wide_address_enable,
	output logic [23:0] coef_start_address,
	output logic biquad_first_coef_flag,
	output logic biquad_group_start,
	output logic pin0_output_enable,
	output logic pin1_output_enable,
	output logic pin2_output_enable
);
	logic [7:0] ctrl0;
	logic [7:0] addr_high;
	logic [7:0] coef_start_addr_middle;
	logic [7:0] coef_start_addr_low;
	logic [7:0] biquad_write_control;
	logic [7:0] supply_voltage_sample;
	logic [2:0] pin_direction_control;
	logic [7:0] next_rdata;
	boot_status_if bs();

	assign bs.load_start = load_start;
	assign bs.load_done = load_done;
	assign bs.crc_error = crc_error;

	boot_status_tracker u_tracker (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.bs(bs)
	);

	// ==========================================
	// write decode: one strobe per writable register
	// status and supply offsets decode to nothing, so host writes there
	// cannot disturb what the tracker and the sampler hold
	logic hit_ctrl0;
	logic hit_addr_high;
	logic hit_addr_middle;
	logic hit_addr_low;
	logic hit_biquad;
	logic hit_pin_dir;
	always_comb begin
		hit_ctrl0 = 1'b0;
		hit_addr_high = 1'b0;
		hit_addr_middle = 1'b0;
		hit_addr_low = 1'b0;
		hit_biquad = 1'b0;
		hit_pin_dir = 1'b0;
		if (reg_write) begin
			case (reg_addr)
				ctrl0_offset: hit_ctrl0 = 1'b1;
				addr_high_offset: hit_addr_high = 1'b1;
				addr_middle_offset: hit_addr_middle = 1'b1;
				addr_low_offset: hit_addr_low = 1'b1;
				biquad_ctrl_offset: hit_biquad = 1'b1;
				pin_dir_offset: hit_pin_dir = 1'b1;
				default: hit_ctrl0 = 1'b0;
			endcase
		end
	end

	// ==========================================
	// load control: only the source and wide address bits are kept,
	// the rest of the byte reads back zero
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl0 <= ctrl0_reset;
		end else if (hit_ctrl0) begin
			ctrl0 <= reg_wdata & ctrl0_mask;
		end
	end

	// ==========================================
	// high start address byte
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			addr_high <= addr_reset;
		end else if (hit_addr_high) begin
			addr_high <= reg_wdata;
		end
	end

	// ==========================================
	// middle start address byte
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			coef_start_addr_middle <= addr_reset;
		end else if (hit_addr_middle) begin
			coef_start_addr_middle <= reg_wdata;
		end
	end

	// ==========================================
	// low start address byte
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			coef_start_addr_low <= addr_reset;
		end else if (hit_addr_low) begin
			coef_start_addr_low <= reg_wdata;
		end
	end

	// ==========================================
	// biquad write control, all eight bits stored
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			biquad_write_control <= biquad_ctrl_reset;
		end else if (hit_biquad) begin
			biquad_write_control <= reg_wdata;
		end
	end

	// ==========================================
	// pin direction, only the three pin bits exist
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_direction_control <= pin_dir_reset;
		end else if (hit_pin_dir) begin
			pin_direction_control <= reg_wdata[2:0];
		end
	end

	// ==========================================
	// supply measurement, only the sampler updates it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			supply_voltage_sample <= supply_reset;
		end else if (sample_valid) begin
			supply_voltage_sample <= sample_code;
		end
	end

	// ==========================================
	// load control copies; every output lags its register by one edge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			load_from_memory <= 1'b0;
			wide_address_enable <= 1'b0;
		end else begin
			load_from_memory <= ctrl0[load_source_bit];
			wide_address_enable <= ctrl0[wide_address_bit];
		end
	end

	// ==========================================
	// start address, high byte most significant
	// high byte is carried in narrow mode too; the engine ignores it there
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			coef_start_address <= 24'h000000;
		end else begin
			coef_start_address <= {addr_high, coef_start_addr_middle,
				coef_start_addr_low};
		end
	end

	// ==========================================
	// biquad grouping
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			biquad_first_coef_flag <= 1'b0;
			biquad_group_start <= 1'b0;
		end else begin
			biquad_first_coef_flag <=
				biquad_write_control[first_coef_bit];
			// a coefficient write with the marker set opens a new group
			biquad_group_start <= biquad_coef_write &
				biquad_write_control[first_coef_bit];
		end
	end

	// ==========================================
	// pin output enables, one flop per pin
	// 1 lets the pin drive, 0 leaves it an input
	logic [2:0] pin_oe;
	for (genvar i = 0; i < 3; i++) begin : g_pin_oe
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				pin_oe[i] <= pin_dir_reset[i];
			end else begin
				pin_oe[i] <= pin_direction_control[i];
			end
		end
	end
	assign pin0_output_enable = pin_oe[0];
	assign pin1_output_enable = pin_oe[1];
	assign pin2_output_enable = pin_oe[2];

	// ==========================================
	// read mux
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			ctrl0_offset: next_rdata = ctrl0;
			addr_high_offset: next_rdata = addr_high;
			addr_middle_offset: next_rdata = coef_start_addr_middle;
			addr_low_offset: next_rdata = coef_start_addr_low;
			boot_status_offset: next_rdata = {6'h00, bs.status};
			biquad_ctrl_offset: next_rdata = biquad_write_control;
			supply_offset: next_rdata = supply_voltage_sample;
			pin_dir_offset: next_rdata = {5'h00, pin_direction_control};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

/* File: verif/coef_regs_sva.sv */
// Purpose: port assertions for the coefficient boot register bank
// Assumes: one clock, async active-low reset
// Notes: derived outputs lag a write by two edges
`timescale 1ns/1ps
`default_nettype none
module coef_regs_sva
	import coef_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic load_start,
	input wire logic load_done,
	input wire logic crc_error,
	input wire logic biquad_coef_write,
	input wire logic load_from_memory,
	input wire logic wide_address_enable,
	input wire logic [23:0] coef_start_address,
	input wire logic biquad_first_coef_flag,
	input wire logic biquad_group_start,
	input wire logic pin0_output_enable,
	input wire logic pin1_output_enable,
	input wire logic pin2_output_enable
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire rs = reg_read && reg_addr == boot_status_offset;
	wire [2:0] pins = {pin2_output_enable, pin1_output_enable,
		pin0_output_enable};
	AST_DIR: assert property (reg_write && reg_addr == pin_dir_offset
		|=> ##1 pins == $past(reg_wdata[2:0], 2)) else $error("dir");
	AST_LOW: assert property (reg_write && reg_addr == addr_low_offset
		|=> ##1 coef_start_address[7:0] == $past(reg_wdata, 2))
		else $error("low");
	AST_MID: assert property (
		reg_write && reg_addr == addr_middle_offset
		|=> ##1 coef_start_address[15:8] == $past(reg_wdata, 2))
		else $error("mid");
	AST_SRC: assert property (reg_write && reg_addr == ctrl0_offset
		|=> ##1 load_from_memory == $past(reg_wdata[0], 2)) else $error("src");
	AST_RSVD: assert property (rs |=> reg_rdata[7:2] == 6'h00)
		else $error("reserved");
	AST_DONE: assert property (
		load_done ##1 (rs && !load_start && !load_done)
		|=> reg_rdata[1:0] == {$past(crc_error, 2), 1'h1})
		else $error("done");
	AST_CLR: assert property (
		load_start && !load_done ##1 (rs && !load_done)
		|=> reg_rdata[1:0] == 2'h0) else $error("clear");
	AST_GRP: assert property (
		biquad_group_start |-> $past(biquad_coef_write))
		else $error("group");
	AST_WIDE: assert property (
		reg_write && reg_addr == ctrl0_offset
		|=> ##1 wide_address_enable == $past(reg_wdata[wide_address_bit], 2))
		else $error("wide");
	AST_FIRST: assert property (
		reg_write && reg_addr == biquad_ctrl_offset
		|=> ##1 biquad_first_coef_flag == $past(reg_wdata[0], 2))
		else $error("first");
endmodule
`default_nettype wire

/* File: verif/boot_engine_model.sv */
// Purpose: memory load engine stand-in driving boot events
// Assumes: go is a one-cycle bench request
// Notes: crc_error keeps fail through load_done and one cycle after it, and shows the inverse elsewhere
`timescale 1ns/1ps
`default_nettype none
module boot_engine_model (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic fail,
	output logic load_start = 1'h0,
	output logic load_done = 1'h0,
	output logic crc_error = 1'h0
);
	always @(posedge ref_clk) begin
		crc_error <= ~fail;
		if (go) begin
			load_start <= 1'h1;
			@(posedge ref_clk) load_start <= 1'h0;
			repeat (2) @(posedge ref_clk);
			load_done <= 1'h1;
			crc_error <= fail;
			@(posedge ref_clk) load_done <= 1'h0;
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: self-checking bench for the coefficient boot register bank
// Assumes: inputs change by nonblocking assignment at rising edges
// Notes: each scenario task checks its own results
`timescale 1ns/1ps
`default_nettype none
module tb;
	import coef_regs_pkg::*;
	logic ref_clk = 1'h0, nrst = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
	logic sample_valid = 1'h0, biquad_coef_write = 1'h0, go = 1'h0;
	logic fail = 1'h0, load_start, load_done, crc_error, load_from_memory;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, sample_code = 8'h00;
	logic [7:0] reg_rdata;
	logic [23:0] coef_start_address;
	logic wide_address_enable, biquad_first_coef_flag, biquad_group_start;
	logic pin0_output_enable, pin1_output_enable, pin2_output_enable;
	wire [23:0] pins = {21'h0, pin2_output_enable, pin1_output_enable,
		pin0_output_enable};
	int mismatches = 0, check_count = 0;
	always #2.5 ref_clk = ~ref_clk;
	coef_boot_gpio_dir_regs DUT (.*);
	boot_engine_model engine (.*);
	task ck(input logic [23:0] s, input logic [23:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_write <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk) reg_write <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_read <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk) reg_read <= 1'h0;
		@(negedge ref_clk) ck(24'(reg_rdata), 24'(e));
	endtask
	task t_reset;
		logic [7:0] offs [6] = '{addr_high_offset, addr_middle_offset,
			addr_low_offset, boot_status_offset, supply_offset, pin_dir_offset};
		foreach (offs[i]) rd(offs[i], 8'h00);
		ck(pins, 24'h0);
	endtask
	task t_regs;
		wr(addr_high_offset, 8'ha5);
		wr(addr_middle_offset, 8'h3c);
		wr(addr_low_offset, 8'hc3);
		wr(ctrl0_offset, 8'hff);
		wr(8'h5d, 8'hff);
		rd(8'h5d, 8'h00);
		rd(addr_middle_offset, 8'h3c);
		rd(addr_high_offset, 8'ha5);
		rd(addr_low_offset, 8'hc3);
		rd(ctrl0_offset, 8'h21);
		ck(coef_start_address, 24'ha53cc3);
		ck(24'({wide_address_enable, load_from_memory}), 24'h3);
		wr(pin_dir_offset, 8'h05);
		rd(pin_dir_offset, 8'h05);
		ck(pins, 24'h5);
	endtask
	task t_mid_reset;
		@(posedge ref_clk) nrst <= 1'h0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'h1;
		@(negedge ref_clk);
		ck(pins, 24'h0);
		ck(coef_start_address, 24'h0);
		rd(addr_middle_offset, 8'h00);
		rd(pin_dir_offset, 8'h00);
	endtask
	task t_boot(input logic f, input logic [7:0] e);
		@(posedge ref_clk);
		go <= 1'h1;
		fail <= f;
		@(posedge ref_clk) go <= 1'h0;
		rd(boot_status_offset, 8'h00);
		@(posedge ref_clk);
		rd(boot_status_offset, e);
		wr(boot_status_offset, 8'h00);
		rd(boot_status_offset, e);
	endtask
	task t_sup(input logic [7:0] c);
		@(posedge ref_clk);
		sample_valid <= 1'h1;
		sample_code <= c;
		@(posedge ref_clk) sample_valid <= 1'h0;
		sample_code <= ~c;
		wr(supply_offset, 8'h5a);
		rd(supply_offset, c);
	endtask
	task t_bq(input logic [7:0] d);
		wr(biquad_ctrl_offset, d);
		rd(biquad_ctrl_offset, d);
		@(posedge ref_clk) biquad_coef_write <= 1'h1;
		@(posedge ref_clk) biquad_coef_write <= 1'h0;
		@(negedge ref_clk);
		ck(24'(biquad_first_coef_flag), 24'(d[0]));
		ck(24'(biquad_group_start), 24'(d[0]));
	endtask
	task close_out;
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'h1;
		t_reset();
		t_regs();
		t_mid_reset();
		t_boot(1'h1, 8'h03);
		t_boot(1'h0, 8'h01);
		t_sup(8'hdf);
		t_sup(8'h25);
		t_bq(8'h01);
		t_bq(8'h00);
		close_out();
	end
	initial begin
		#8000;
		mismatches++;
		close_out();
	end
endmodule
bind coef_boot_gpio_dir_regs coef_regs_sva chk (.*);
`default_nettype wire
